// [hdl/pwm_and_info_command_unit.v]
// Command unit: info queries, free-running RF modulator and a timed RF enable.
// Assumes an APB master on clk_in and a temperature sensor on another clock.
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "cmd_unit_regs.vh"

// Contract
// - Uptime counts from reset and restarts at zero on every reset.
// - Uptime query answers command, channel and whole seconds.
// - Temperature query answers channel and controller temperature in degrees C.
// - Version query answers developer id, major, minor, build, hotfix, date, time.
// - Modulator frequency spans 1000 to 19800 Hz; host stays inside it.
// - Above the upper frequency the output stays continuously on.
// - Settings query returns frequency, reserved, trigger mode, reserved, duty.
// - Trigger mode one means free running; two and three are reserved.
// - Duty set takes a percentage from 0 to 100, on time over period.
// - Duty of 100 percent switches modulation off; no other enable exists.
// - Duty giving an on pulse under 50 us is rejected; the code checks this on duty set only, not on frequency set.
// - Modulator switches RF at set rate and duty, pulsing power reads.
// - Timed enable turns RF on once for the given microseconds, then OK; the code answers OK as the pulse starts.
module pwm_and_info_command_unit #(
  parameter [31:0] DEV_ID      = 32'h0000_00a5, // Arbitrary developer identifier
  parameter [7:0]  VER_MAJOR   = 8'h01,         // Firmware major revision
  parameter [7:0]  VER_MINOR   = 8'h00,         // Firmware minor revision
  parameter [7:0]  VER_BUILD   = 8'h00,         // Firmware build number
  parameter [7:0]  VER_HOTFIX  = 8'h00,         // Hotfix, zero when absent
  parameter [31:0] DATE_STAMP  = 32'h0000_0000, // Compile date, packed
  parameter [31:0] TIME_STAMP  = 32'h0000_0000, // Compile time, packed
  parameter [31:0] SEC_CYCLES  = `CLK_HZ,       // Clock cycles per second
  parameter        TEMP_W      = 16             // Temperature width, centi-degrees
) (
  input  wire              clk_in,        // 100 MHz clock
  input  wire              nrst_in,       // Async reset, active low
  input  wire              psel_in,       // APB select
  input  wire              penable_in,    // APB enable
  input  wire              pwrite_in,     // APB write
  input  wire [7:0]        paddr_in,      // APB byte address
  input  wire [31:0]       pwdata_in,     // APB write data
  output wire              pready_out,    // APB ready
  output reg  [31:0]       prdata_out,    // APB read data
  output reg               pslverr_out,   // APB error
  input  wire [TEMP_W-1:0] temp_in,       // Controller temperature, async
  output reg               rf_mod_out,    // Modulated RF enable
  output reg               rf_timed_out,  // Timed RF enable
  output reg               meas_trig_out  // Power read trigger pulse
);

  localparam [2:0] ST_IDLE    = 3'h0;
  localparam [2:0] ST_DIV_PER = 3'h1;
  localparam [2:0] ST_DIV_ON  = 3'h2;
  localparam [2:0] ST_FINISH  = 3'h3;

  localparam [31:0] MIN_ON_CYC = `MIN_ON_US * `CLK_MHZ;
  localparam [31:0] RST_PERIOD = `CLK_HZ / `FREQ_RST;

  reg  [2:0]        state_reg;
  reg  [31:0]       arg0_reg;
  reg  [31:0]       arg1_reg;
  reg  [3:0]        op_reg;
  reg  [7:0]        ch_reg;
  reg               done_reg;
  reg               ok_reg;
  reg  [31:0]       rsp0_reg;
  reg  [31:0]       rsp1_reg;
  reg  [31:0]       rsp2_reg;
  reg  [31:0]       rsp3_reg;
  reg  [31:0]       freq_reg;
  reg  [31:0]       duty_reg;
  reg  [31:0]       period_reg;
  reg  [31:0]       on_reg;
  reg  [31:0]       pend_freq_reg;
  reg  [31:0]       pend_duty_reg;
  reg  [31:0]       pend_per_reg;
  reg               from_freq_reg;
  reg  [31:0]       div_num_reg;
  reg  [31:0]       div_den_reg;
  reg  [31:0]       div_rem_reg;
  reg  [5:0]        div_cnt_reg;
  reg  [31:0]       sec_pre_reg;
  reg  [31:0]       uptime_reg;
  reg  [TEMP_W-1:0] temp_s1_reg;
  reg  [TEMP_W-1:0] temp_s2_reg;
  reg  [31:0]       mod_cnt_reg;
  reg  [31:0]       timed_us_reg;
  reg  [7:0]        us_pre_reg;
  reg  [31:0]       rd_next;
  reg               err_next;

  wire        busy     = (state_reg != ST_IDLE);
  wire        setup    = psel_in & ~penable_in;
  wire        access   = psel_in & penable_in;
  wire        wr       = access & pwrite_in;
  wire        start    = wr & (paddr_in == `OFS_CMD) & ~busy & ~pslverr_out; // Agrees with error
  wire [31:0] rem_sh   = {div_rem_reg[30:0], div_num_reg[31]};
  wire        rem_ge   = (rem_sh >= div_den_reg);
  wire        div_last = (div_cnt_reg == 6'h01);
  // Full-on covers both duty 100 and a rate too fast to modulate
  wire        mod_off  = (duty_reg == `DUTY_MAX) | (freq_reg > `FREQ_MAX);

  // No wait states: registers answer in the access phase
  assign pready_out = 1'b1;

  // Read mux; unmapped addresses and busy command writes flag an error
  always @* begin
    rd_next  = 32'h0000_0000;
    err_next = 1'b0;
    case (paddr_in)
      `OFS_CMD:    begin
        rd_next  = {16'h0000, ch_reg, 4'h0, op_reg};
        err_next = pwrite_in & busy;
      end
      `OFS_ARG0:   rd_next = arg0_reg;
      `OFS_ARG1:   rd_next = arg1_reg;
      `OFS_STATUS: begin
        rd_next = {13'h0000, busy, ok_reg, done_reg, ch_reg, 4'h0, op_reg};
      end
      `OFS_RSP0:   rd_next = rsp0_reg;
      `OFS_RSP1:   rd_next = rsp1_reg;
      `OFS_RSP2:   rd_next = rsp2_reg;
      `OFS_RSP3:   rd_next = rsp3_reg;
      `OFS_UPTIME: rd_next = uptime_reg;
      `OFS_FREQ:   rd_next = freq_reg;
      `OFS_DUTY:   rd_next = duty_reg;
      default:     err_next = 1'b1;
    endcase
  end

  // Read data and error are registered in the setup phase
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else if (setup) begin
      prdata_out  <= pwrite_in ? 32'h0000_0000 : rd_next;
      pslverr_out <= err_next;
    end
  end

  // Argument registers; the command register itself only triggers
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      arg0_reg <= 32'h0000_0000;
      arg1_reg <= 32'h0000_0000;
    end else if (wr) begin
      if (paddr_in == `OFS_ARG0) arg0_reg <= pwdata_in;
      if (paddr_in == `OFS_ARG1) arg1_reg <= pwdata_in;
    end
  end

  // Uptime in whole seconds, cleared only by reset
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sec_pre_reg <= 32'h0000_0000;
      uptime_reg  <= 32'h0000_0000;
    end else if (sec_pre_reg == SEC_CYCLES - 32'h0000_0001) begin
      sec_pre_reg <= 32'h0000_0000;
      uptime_reg  <= uptime_reg + 32'h0000_0001;
    end else begin
      sec_pre_reg <= sec_pre_reg + 32'h0000_0001;
    end
  end

  // Two stages per bit; no word handshake, so the sensor must hold each value steady
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      temp_s1_reg <= {TEMP_W{1'b0}};
      temp_s2_reg <= {TEMP_W{1'b0}};
    end else begin
      temp_s1_reg <= temp_in;
      temp_s2_reg <= temp_s1_reg;
    end
  end

  // Command sequencer with a shared serial divider for period and on time
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg     <= ST_IDLE;
      op_reg        <= 4'h0;
      ch_reg        <= 8'h00;
      done_reg      <= 1'b0;
      ok_reg        <= 1'b0;
      rsp0_reg      <= 32'h0000_0000;
      rsp1_reg      <= 32'h0000_0000;
      rsp2_reg      <= 32'h0000_0000;
      rsp3_reg      <= 32'h0000_0000;
      freq_reg      <= `FREQ_RST;
      duty_reg      <= `DUTY_RST;
      period_reg    <= RST_PERIOD;
      on_reg        <= RST_PERIOD;
      pend_freq_reg <= `FREQ_RST;
      pend_duty_reg <= `DUTY_RST;
      pend_per_reg  <= RST_PERIOD;
      from_freq_reg <= 1'b0;
      div_num_reg   <= 32'h0000_0000;
      div_den_reg   <= 32'h0000_0001;
      div_rem_reg   <= 32'h0000_0000;
      div_cnt_reg   <= 6'h00;
      timed_us_reg  <= 32'h0000_0000;
    end else begin
      if (timed_us_reg != 32'h0000_0000 && us_pre_reg == `CLK_MHZ - 8'h01)
        timed_us_reg <= timed_us_reg - 32'h0000_0001;
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            op_reg    <= pwdata_in[`CMD_OP_MSB:`CMD_OP_LSB];
            ch_reg    <= pwdata_in[`CMD_CH_MSB:`CMD_CH_LSB];
            done_reg  <= 1'b0;
            ok_reg    <= 1'b0;
            state_reg <= ST_FINISH;
            rsp0_reg  <= 32'h0000_0000;
            rsp1_reg  <= 32'h0000_0000;
            rsp2_reg  <= 32'h0000_0000;
            rsp3_reg  <= 32'h0000_0000;
            case (pwdata_in[`CMD_OP_MSB:`CMD_OP_LSB])
              `OP_UPTIME: begin
                rsp0_reg <= uptime_reg;
                ok_reg   <= 1'b1;
              end
              `OP_TEMP: begin
                rsp0_reg <= {{(32-TEMP_W){temp_s2_reg[TEMP_W-1]}}, temp_s2_reg};
                ok_reg   <= 1'b1;
              end
              `OP_VERSION: begin
                rsp0_reg <= DEV_ID;
                rsp1_reg <= {VER_MAJOR, VER_MINOR, VER_BUILD, VER_HOTFIX};
                rsp2_reg <= DATE_STAMP;
                rsp3_reg <= TIME_STAMP;
                ok_reg   <= 1'b1;
              end
              `OP_SETTINGS: begin
                rsp0_reg <= freq_reg;
                rsp1_reg <= {30'h0000_0000, `TRIG_FREE_RUN};
                rsp2_reg <= duty_reg;
                ok_reg   <= 1'b1;
              end
              `OP_FREQ_SET: begin
                // Low rates are refused; high rates are taken and run full-on
                if (arg0_reg >= `FREQ_MIN) begin
                  pend_freq_reg <= arg0_reg;
                  pend_duty_reg <= duty_reg;
                  from_freq_reg <= 1'b1;
                  div_num_reg   <= `CLK_HZ;
                  div_den_reg   <= arg0_reg;
                  div_rem_reg   <= 32'h0000_0000;
                  div_cnt_reg   <= `DIV_STEPS;
                  state_reg     <= ST_DIV_PER;
                end
              end
              `OP_DUTY_SET: begin
                if (arg0_reg == `DUTY_MAX) begin
                  duty_reg <= arg0_reg;
                  on_reg   <= period_reg;
                  ok_reg   <= 1'b1;
                end else if (arg0_reg < `DUTY_MAX) begin
                  pend_freq_reg <= freq_reg;
                  pend_duty_reg <= arg0_reg;
                  pend_per_reg  <= period_reg;
                  from_freq_reg <= 1'b0;
                  div_num_reg   <= period_reg * arg0_reg;
                  div_den_reg   <= `DUTY_MAX;
                  div_rem_reg   <= 32'h0000_0000;
                  div_cnt_reg   <= `DIV_STEPS;
                  state_reg     <= ST_DIV_ON;
                end
              end
              `OP_TIMED_EN: begin
                // A wrong enable argument is refused rather than guessed at
                if (arg0_reg == `TIMED_EN_ARG) begin
                  timed_us_reg <= arg1_reg;
                  ok_reg       <= 1'b1;
                end
              end
              default: ok_reg <= 1'b0;
            endcase
          end
        end
        ST_DIV_PER, ST_DIV_ON: begin
          div_rem_reg <= rem_ge ? rem_sh - div_den_reg : rem_sh;
          div_num_reg <= {div_num_reg[30:0], rem_ge};
          div_cnt_reg <= div_cnt_reg - 6'h01;
          if (div_last && state_reg == ST_DIV_PER) begin
            // Period known; now derive the on time from the kept duty
            pend_per_reg <= {div_num_reg[30:0], rem_ge};
            div_num_reg  <= {div_num_reg[30:0], rem_ge} * pend_duty_reg;
            div_den_reg  <= `DUTY_MAX;
            div_rem_reg  <= 32'h0000_0000;
            div_cnt_reg  <= `DIV_STEPS;
            state_reg    <= ST_DIV_ON;
          end else if (div_last) begin
            state_reg <= ST_FINISH;
            if (from_freq_reg || {div_num_reg[30:0], rem_ge} >= MIN_ON_CYC) begin
              freq_reg   <= pend_freq_reg;
              duty_reg   <= pend_duty_reg;
              period_reg <= pend_per_reg;
              on_reg     <= {div_num_reg[30:0], rem_ge};
              ok_reg     <= 1'b1;
            end
          end
        end
        ST_FINISH: begin
          done_reg  <= 1'b1;
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Period counter, microsecond prescaler and registered RF outputs;
  // the read trigger lands mid-pulse so power has settled
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mod_cnt_reg   <= 32'h0000_0000;
      us_pre_reg    <= 8'h00;
      rf_mod_out    <= 1'b1;
      rf_timed_out  <= 1'b0;
      meas_trig_out <= 1'b0;
    end else begin
      if (mod_cnt_reg >= period_reg - 32'h0000_0001)
        mod_cnt_reg <= 32'h0000_0000;
      else
        mod_cnt_reg <= mod_cnt_reg + 32'h0000_0001;
      if (us_pre_reg == `CLK_MHZ - 8'h01 || timed_us_reg == 32'h0000_0000)
        us_pre_reg <= 8'h00;
      else
        us_pre_reg <= us_pre_reg + 8'h01;
      rf_mod_out    <= mod_off | (mod_cnt_reg < on_reg);
      meas_trig_out <= ~mod_off & (mod_cnt_reg == {1'b0, on_reg[31:1]});
      rf_timed_out  <= (timed_us_reg != 32'h0000_0000);
    end
  end

endmodule

// [shared/cmd_unit_regs.vh]
// Register map, command codes and limits of the modulator command unit.
// Assumes a 32-bit APB slave with word-aligned registers.
`ifndef CMD_UNIT_REGS_VH
`define CMD_UNIT_REGS_VH

// Register byte offsets
`define OFS_CMD        8'h00
`define OFS_ARG0       8'h04
`define OFS_ARG1       8'h08
`define OFS_STATUS     8'h0c
`define OFS_RSP0       8'h10
`define OFS_RSP1       8'h14
`define OFS_RSP2       8'h18
`define OFS_RSP3       8'h1c
`define OFS_UPTIME     8'h20
`define OFS_FREQ       8'h24
`define OFS_DUTY       8'h28

// Command register fields
`define CMD_OP_MSB     3
`define CMD_OP_LSB     0
`define CMD_CH_MSB     15
`define CMD_CH_LSB     8

// Command codes
`define OP_UPTIME      4'h1
`define OP_TEMP        4'h2
`define OP_VERSION     4'h3
`define OP_FREQ_SET    4'h4
`define OP_SETTINGS    4'h5
`define OP_DUTY_SET    4'h6
`define OP_TIMED_EN    4'h7

// Status register bit positions
`define ST_DONE_BIT    16
`define ST_OK_BIT      17
`define ST_BUSY_BIT    18

// Limits and reset values
`define FREQ_MIN       32'h0000_03e8
`define FREQ_MAX       32'h0000_4d58
`define FREQ_RST       32'h0000_03e8
`define DUTY_MAX       32'h0000_0064
`define DUTY_RST       32'h0000_0064
`define TRIG_FREE_RUN  2'h1
`define TIMED_EN_ARG   32'h0000_0001
`define MIN_ON_US      32'h0000_0032
`define CLK_HZ         32'h05f5_e100
`define CLK_MHZ        32'h0000_0064
`define DIV_STEPS      6'h20

`endif

// [verification/cmd_unit_monitor.sv]
// Checker for the command unit's bus answers and RF outputs.
// Assumes it is bound to the unit's top module and sees only its ports.
`timescale 1ns/1ps
module cmd_unit_monitor (
  input wire        clk_in,       // Clock
  input wire        nrst_in,      // Reset, active low
  input wire        psel_in,      // Select
  input wire        penable_in,   // Enable
  input wire [7:0]  paddr_in,     // Address
  input wire        pready_out,   // Ready
  input wire [31:0] prdata_out,   // Read data
  input wire        pslverr_out,  // Error
  input wire        rf_mod_out,   // Modulated enable
  input wire        rf_timed_out, // Timed enable
  input wire        meas_trig_out // Power read trigger
);
  int on_reg; // Cycles the present on pulse has lasted

  // Run length of the modulated enable, cleared while it is low
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in)
      on_reg <= 0;
    else if (rf_mod_out)
      on_reg <= on_reg + 1;
    else
      on_reg <= 0;
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  a_no_wait: assert property (psel_in && penable_in |-> pready_out)
    else $error("ready low in access phase");
  a_rdata_hold: assert property (!(psel_in && !penable_in) |=> $stable(prdata_out))
    else $error("read data moved outside setup");
  a_unmapped_err: assert property (psel_in && !penable_in && paddr_in >= 8'h2c |=> pslverr_out)
    else $error("unmapped access without error");
  a_reset_on: assert property ($rose(nrst_in) |-> rf_mod_out && !rf_timed_out && !meas_trig_out)
    else $error("outputs wrong after reset");
  a_trig_gap: assert property (meas_trig_out |=> !meas_trig_out [*8])
    else $error("trigger longer than one pulse");
  a_trig_mid: assert property (meas_trig_out |-> $past(rf_mod_out, 8) && rf_mod_out ##1 rf_mod_out [*8])
    else $error("trigger outside on pulse");
  a_min_on: assert property ($fell(rf_mod_out) |-> on_reg >= 5000)
    else $error("on pulse shorter than 50 us");
  a_timed_min: assert property ($rose(rf_timed_out) |-> rf_timed_out [*8])
    else $error("timed enable too short");
endmodule

bind pwm_and_info_command_unit cmd_unit_monitor mon (
  .clk_in, .nrst_in, .psel_in, .penable_in, .paddr_in, .pready_out, .prdata_out,
  .pslverr_out, .rf_mod_out, .rf_timed_out, .meas_trig_out
);

// [verification/cmd_host_model.sv]
// Host model: bus master that sends commands to the unit.
// Assumes callers enter its task at or just after a clock edge.
`timescale 1ns/1ps
module cmd_host_model (
  input  wire         clk_in,      // Clock
  output logic        psel_out,    // Select
  output logic        penable_out, // Enable
  output logic        pwrite_out,  // Direction
  output logic [7:0]  paddr_out,   // Address
  output logic [31:0] pwdata_out,  // Write data
  input  wire         pready_in,   // Ready
  input  wire  [31:0] prdata_in,   // Read data
  input  wire         pslverr_in   // Error
);
  // Idle bus from time zero
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 8'h00;
    pwdata_out = 32'h0;
  end

  // One transfer, held until ready; write data inverted once released
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge clk_in);
    psel_out <= 1'b1;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clk_in);
    penable_out <= 1'b1;
    do @(posedge clk_in); while (pready_in !== 1'b1);
    r = prdata_in;
    e = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    pwdata_out <= ~d;
  endtask
endmodule

// [verification/pwm_and_info_command_unit_bench.sv]
// Bench for the command unit: host model on the bus, one task per scenario.
// Assumes the unit's register header; uptime second shortened to 1000 cycles.
`timescale 1ns/1ps
`include "cmd_unit_regs.vh"
module pwm_and_info_command_unit_bench;
  logic        clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic [15:0] temp_in = 16'hf830; // -20.00 C
  wire         psel, pen, pwr, prdy, perr, rf_mod, rf_tmd, trig;
  wire  [7:0]  paddr;
  wire  [31:0] pwdata, prdata;
  int          err_total = 0;
  int          n_compared = 0;

  // 100 MHz clock
  always #5 clk_in = ~clk_in;

  cmd_host_model host (.clk_in, .psel_out(psel), .penable_out(pen), .pwrite_out(pwr),
    .paddr_out(paddr), .pwdata_out(pwdata), .pready_in(prdy), .prdata_in(prdata),
    .pslverr_in(perr));
  // Identity and version values are arbitrary bench choices
  pwm_and_info_command_unit #(.DEV_ID(32'h0000_005a), .VER_MINOR(8'h02),
    .VER_BUILD(8'h03), .VER_HOTFIX(8'h04), .DATE_STAMP(32'h0000_1234),
    .TIME_STAMP(32'h0000_5678), .SEC_CYCLES(32'd1000)) DUT (.clk_in, .nrst_in,
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .pready_out(prdy), .prdata_out(prdata), .pslverr_out(perr),
    .temp_in, .rf_mod_out(rf_mod), .rf_timed_out(rf_tmd), .meas_trig_out(trig));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] v;
    logic e;
    host.xfer(1'b0, a, 32'h0, v, e);
    chk($sformatf("reg %h", a), x, v);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    logic e;
    host.xfer(1'b1, a, d, v, e);
  endtask
  // Polls for done, bounded, then judges the status word
  task automatic fin(input logic [3:0] op, input logic [7:0] ch, input logic ok);
    logic [31:0] s;
    logic e;
    for (int i = 0; i < 100; i++) begin
      host.xfer(1'b0, `OFS_STATUS, 32'h0, s, e);
      if (s[`ST_DONE_BIT] === 1'b1) break;
    end
    chk("status", {13'h0, 1'b0, ok, 1'b1, ch, 4'h0, op}, s);
  endtask
  task automatic run(input logic [3:0] op, input logic [7:0] ch, input logic [31:0] a0,
                     input logic [31:0] a1, input logic ok);
    wr(`OFS_ARG0, a0);
    wr(`OFS_ARG1, a1);
    wr(`OFS_CMD, {16'h0, ch, 4'h0, op});
    fin(op, ch, ok);
  endtask
  // Counts cycles off and triggers over a span
  task automatic ticks(input int n, output int lo, output int tr);
    lo = 0;
    tr = 0;
    repeat (n) begin
      @(posedge clk_in) #1;
      lo += (rf_mod !== 1'b1);
      tr += (trig !== 1'b0);
    end
  endtask
  task automatic do_reset();
    nrst_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    nrst_in <= 1'b1;
  endtask

  task automatic t_reset();
    rc(`OFS_FREQ, `FREQ_RST);
    rc(`OFS_DUTY, `DUTY_RST);
    rc(`OFS_STATUS, 32'h0);
    chk("rf_mod", 1, rf_mod);
    $display("test reset done");
  endtask
  task automatic t_info();
    run(`OP_TEMP, 8'h03, 0, 0, 1'b1);
    rc(`OFS_RSP0, 32'hffff_f830);
    run(`OP_VERSION, 8'h07, 0, 0, 1'b1);
    rc(`OFS_RSP0, 32'h0000_005a);
    rc(`OFS_RSP1, 32'h0102_0304);
    rc(`OFS_RSP2, 32'h0000_1234);
    rc(`OFS_RSP3, 32'h0000_5678);
    run(4'h9, 8'h08, 0, 0, 1'b0);
    $display("test info done");
  endtask
  task automatic t_bus();
    logic [31:0] v;
    logic e;
    host.xfer(1'b0, 8'h40, 32'h0, v, e);
    chk("unmapped err", 1, e);
    chk("unmapped data", 0, v);
    wr(`OFS_ARG0, 32'd10000);
    wr(`OFS_ARG1, 32'h0);
    wr(`OFS_CMD, {16'h0, 8'h01, 4'h0, `OP_FREQ_SET});
    host.xfer(1'b1, `OFS_CMD, {16'h0, 8'h09, 4'h0, `OP_UPTIME}, v, e);
    chk("busy err", 1, e);
    fin(`OP_FREQ_SET, 8'h01, 1'b1);
    $display("test bus done");
  endtask
  task automatic t_duty();
    int hi = 0;
    int per = 0;
    int tr = 0;
    run(`OP_DUTY_SET, 8'h02, 101, 0, 1'b0);
    run(`OP_DUTY_SET, 8'h02, 49, 0, 1'b0);
    run(`OP_DUTY_SET, 8'h02, 62, 0, 1'b1);
    rc(`OFS_DUTY, 62);
    for (int i = 0; i < 30000 && rf_mod !== 1'b0; i++) @(posedge clk_in) #1;
    for (int i = 0; i < 30000 && rf_mod !== 1'b1; i++) @(posedge clk_in) #1;
    while (rf_mod === 1'b1 && per < 30000) begin
      per++;
      hi++;
      tr += trig;
      @(posedge clk_in) #1;
    end
    while (rf_mod === 1'b0 && per < 30000) begin
      per++;
      @(posedge clk_in) #1;
    end
    chk("on time", 6200, hi);
    chk("period", 10000, per);
    chk("triggers", 1, tr);
    run(`OP_SETTINGS, 8'h02, 0, 0, 1'b1);
    rc(`OFS_RSP0, 32'd10000);
    rc(`OFS_RSP1, {30'h0, `TRIG_FREE_RUN});
    rc(`OFS_RSP2, 62);
    $display("test duty done");
  endtask
  task automatic t_full();
    int lo;
    int tr;
    run(`OP_DUTY_SET, 8'h04, 100, 0, 1'b1);
    ticks(12000, lo, tr);
    chk("full on", 0, lo);
    chk("no trigger", 0, tr);
    run(`OP_FREQ_SET, 8'h04, 999, 0, 1'b0);
    run(`OP_FREQ_SET, 8'h04, 19800, 0, 1'b1);
    run(`OP_DUTY_SET, 8'h04, 99, 0, 1'b0);
    run(`OP_FREQ_SET, 8'h04, 1000, 0, 1'b1);
    run(`OP_DUTY_SET, 8'h04, 50, 0, 1'b1);
    run(`OP_FREQ_SET, 8'h04, 19801, 0, 1'b1);
    ticks(100, lo, tr);
    ticks(12000, lo, tr);
    chk("over range on", 0, lo);
    $display("test full done");
  endtask
  task automatic t_timed();
    int n = 0;
    run(`OP_TIMED_EN, 8'h05, 2, 20, 1'b0);
    chk("timed idle", 0, rf_tmd);
    wr(`OFS_ARG0, `TIMED_EN_ARG);
    wr(`OFS_ARG1, 20);
    wr(`OFS_CMD, {16'h0, 8'h05, 4'h0, `OP_TIMED_EN});
    for (int i = 0; i < 300 && rf_tmd !== 1'b1; i++) @(posedge clk_in) #1;
    while (rf_tmd === 1'b1 && n < 5000) begin
      n++;
      @(posedge clk_in) #1;
    end
    chk("timed width", 1, n >= 1999 && n <= 2001);
    fin(`OP_TIMED_EN, 8'h05, 1'b1);
    $display("test timed done");
  endtask
  task automatic t_uptime();
    do_reset();
    rc(`OFS_UPTIME, 0);
    repeat (2500) @(posedge clk_in);
    run(`OP_UPTIME, 8'h06, 0, 0, 1'b1);
    rc(`OFS_RSP0, 2);
    rc(`OFS_UPTIME, 2);
    $display("test uptime done");
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial begin
    do_reset();
    t_reset();
    t_info();
    t_bus();
    t_duty();
    t_full();
    t_timed();
    t_uptime();
    print_verdict();
  end
  // Watchdog, about twice the expected run
  initial begin
    repeat (90000) @(posedge clk_in);
    err_total++;
    print_verdict();
  end
endmodule
